// >>> shared/timer_counter16_params.svh
// Register map, field positions, reset values and timing counts of the 16-bit timer/counter
`ifndef TIMER_COUNTER16_PARAMS_SVH
`define TIMER_COUNTER16_PARAMS_SVH

// Register addresses
`define TC_ADDR_CONTROL 8'h10
`define TC_ADDR_COUNT_LO 8'h11
`define TC_ADDR_COUNT_HI 8'h12
`define TC_ADDR_FLAG 8'h13
`define TC_ADDR_ENABLE 8'h14

// Control register fields
`define TC_BIT_RUN 0
`define TC_BIT_CS 1
`define TC_BIT_SYNC_N 2
`define TC_BIT_OSC_EN 3
`define TC_BIT_PS_LO 4
`define TC_BIT_PS_HI 5
`define TC_CONTROL_RESET 6'h00
`define TC_FLAG_BIT 0
`define TC_IEN_BIT 0

// Count limits
`define TC_COUNT_MAX 16'hFFFF
`define TC_COUNT_ZERO 16'h0000

// Instruction cycle from a 20 MHz oscillator
`define TC_OSC_PERIOD_NS 50
`define TC_INSTR_PERIOD_NS 200
`define TC_INSTR_CYCLES (`TC_INSTR_PERIOD_NS / `TC_OSC_PERIOD_NS)

`endif

// >>> shared/timer_counter16_pkg.sv
// Types shared by the timer/counter design files
package timer_counter16_pkg;
  // Prescale codes in field order
  typedef enum logic [1:0] {PRE_DIV1, PRE_DIV2, PRE_DIV4, PRE_DIV8} prescale_e;
  // The 16-bit count value
  typedef logic [15:0] count_t;
endpackage

// >>> rtl/tc_sync_2ff.sv
// Two-flop synchroniser for one level
module tc_sync_2ff (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg; // First stage, read only by the second
  logic q_reg; // Second stage

  // Plain double flop, no logic between stages
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= i_d;
      q_reg <= meta_reg;
    end
  end

  assign o_q = q_reg;
endmodule

// >>> rtl/tc_prescaler.sv
// Input prescaler: counts input ticks, passes every 1st, 2nd, 4th or 8th
module tc_prescaler #(
  parameter int PRESC_W = 3
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire timer_counter16_pkg::prescale_e i_select,
  output logic o_tick
);
  logic [PRESC_W-1:0] cnt_reg; // Ripple chain state, modelled on the system clock
  logic [PRESC_W-1:0] cnt_next;
  logic last_of_group; // This input tick completes a divide group

  // Code 00 passes every tick; others wait for all low stages at one
  assign last_of_group = (i_select == timer_counter16_pkg::PRE_DIV1) ? 1'b1 :
                         (i_select == timer_counter16_pkg::PRE_DIV2) ? cnt_reg[0] :
                         (i_select == timer_counter16_pkg::PRE_DIV4) ? &cnt_reg[1:0] :
                         &cnt_reg[2:0];
  assign o_tick = i_tick & last_of_group;
  // Clear wins over a coincident tick
  assign cnt_next = i_clear ? '0 : (i_tick ? cnt_reg + 1'b1 : cnt_reg);

  // Chain keeps counting regardless of sleep
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// >>> rtl/timer_counter16.sv
// 16-bit timer/counter with prescaler, external input and register port
`include "timer_counter16_params.svh"
module timer_counter16 #(
  parameter int PRESC_W = 3,
  parameter int INSTR_DIV = `TC_INSTR_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [1:0] i_cmp_reset,
  input wire logic i_sleep,
  input wire logic i_osc_input_pin,
  input wire logic i_ext_count_pin,
  input wire logic [1:0] i_port_c_direction,
  output logic [1:0] o_pin_oe,
  output logic [1:0] o_port_c_read,
  output logic o_osc_enable,
  output logic o_overflow_flag,
  output logic o_overflow_irq,
  output logic o_wake
);
  localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

  // Software-visible state
  logic [5:0] control_reg; // Implemented control bits
  logic [5:0] control_next;
  logic [15:0] count_reg; // Holds its value across i_rstn; a compare reset zeros it
  logic [15:0] count_next;
  logic flag_reg; // Latched overflow
  logic flag_next;
  logic ien_reg; // Overflow interrupt enable
  logic ien_next;
  logic [7:0] rdata_reg; // Read data, one cycle after the strobe
  logic [1:0] pin_read_reg; // Port data bits as read by software

  // Internal sequencing state
  logic [DIV_W-1:0] instr_cnt_reg; // Oscillator-to-instruction divider
  logic [DIV_W-1:0] instr_cnt_next;
  logic ext_prev_reg; // Last sample of the selected external input
  logic armed_reg; // Falling edge seen since counter mode began
  logic armed_next;
  logic tog_reg; // Toggle carrying prescaler events to the synchroniser
  logic tog_seen_reg; // Last synchronised toggle value

  // Control field decode
  wire run = control_reg[`TC_BIT_RUN];
  wire cs = control_reg[`TC_BIT_CS];
  wire sync_n = control_reg[`TC_BIT_SYNC_N];
  wire osc_en = control_reg[`TC_BIT_OSC_EN];
  wire [1:0] ps_code = control_reg[`TC_BIT_PS_HI:`TC_BIT_PS_LO];

  // Register strobe decode
  wire wr_ctrl = i_wr && (i_addr == `TC_ADDR_CONTROL);
  wire wr_lo = i_wr && (i_addr == `TC_ADDR_COUNT_LO);
  wire wr_hi = i_wr && (i_addr == `TC_ADDR_COUNT_HI);
  wire wr_flag = i_wr && (i_addr == `TC_ADDR_FLAG);
  wire wr_ien = i_wr && (i_addr == `TC_ADDR_ENABLE);
  wire wr_count = wr_lo | wr_hi;
  wire cmp_any = |i_cmp_reset;

  // Internal source: one tick per instruction cycle, stopped in sleep
  wire instr_tick = (instr_cnt_reg == DIV_W'(INSTR_DIV - 1)) && !i_sleep;
  assign instr_cnt_next = instr_tick ? '0 :
                          (i_sleep ? instr_cnt_reg : instr_cnt_reg + 1'b1);

  // External source follows the crystal enable
  wire ext_sel = osc_en ? i_osc_input_pin : i_ext_count_pin;
  wire ext_rise = ext_sel & ~ext_prev_reg;
  wire ext_fall = ~ext_sel & ext_prev_reg;
  wire counter_on = run & cs;
  // Arming drops whenever counter mode stops, so re-enabling needs a new fall
  assign armed_next = !counter_on ? 1'b0 : (armed_reg | ext_fall);
  wire ext_tick = ext_rise & armed_reg & counter_on;

  // Source select; sync bit plays no part in timer mode
  wire src_tick = cs ? ext_tick : (instr_tick & run);
  wire pre_tick; // Prescaler output event
  wire tog_sync; // Synchronised toggle

  tc_prescaler #(
    .PRESC_W(PRESC_W)
  ) u_prescaler (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clear(wr_count),
    .i_tick(src_tick),
    .i_select(timer_counter16_pkg::prescale_e'(ps_code)),
    .o_tick(pre_tick)
  );

  tc_sync_2ff u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(tog_reg),
    .o_q(tog_sync)
  );

  // Synchronised path sits after the prescaler and is off in sleep
  wire use_sync = cs & ~sync_n;
  wire sync_tick = (tog_sync ^ tog_seen_reg) & ~i_sleep;
  // Unsynchronised path counts straight from the prescaler, sleep or not
  wire inc_tick = (use_sync ? sync_tick : pre_tick) & run;
  wire at_max = (count_reg == `TC_COUNT_MAX);
  // Only a real increment wraps; a write or compare reset in that cycle takes over
  wire overflow = inc_tick & at_max & ~wr_count & ~cmp_any;
  // Byte views of the count, used by the checks
  wire [7:0] count_lo = count_reg[7:0];
  wire [7:0] count_hi = count_reg[15:8];

  // Count: software write, then compare reset, then increment
  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      if (wr_lo) begin
        count_next[7:0] = i_wdata;
      end else begin
        count_next[15:8] = i_wdata;
      end
    end else if (cmp_any) begin
      count_next = `TC_COUNT_ZERO;
    end else if (inc_tick) begin
      count_next = count_reg + 16'h0001;
    end
  end

  // Flag: a wrap wins over a software clear in the same cycle
  assign flag_next = (wr_flag ? i_wdata[`TC_FLAG_BIT] : flag_reg) | overflow;
  assign ien_next = wr_ien ? i_wdata[`TC_IEN_BIT] : ien_reg;
  assign control_next = wr_ctrl ? i_wdata[5:0] : control_reg;

  // Read data mux; unmapped addresses read zero
  wire [7:0] rd_mux =
    (i_addr == `TC_ADDR_CONTROL) ? {2'b00, control_reg} :
    (i_addr == `TC_ADDR_COUNT_LO) ? count_reg[7:0] :
    (i_addr == `TC_ADDR_COUNT_HI) ? count_reg[15:8] :
    (i_addr == `TC_ADDR_FLAG) ? {7'h00, flag_reg} :
    (i_addr == `TC_ADDR_ENABLE) ? {7'h00, ien_reg} : 8'h00;

  // Count has no reset by design: i_rstn never clears it
  always_ff @(posedge i_clk) begin
    count_reg <= count_next;
  end

  // Control and status flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      control_reg <= `TC_CONTROL_RESET;
      flag_reg <= 1'b0;
      ien_reg <= 1'b0;
    end else begin
      control_reg <= control_next;
      flag_reg <= flag_next;
      ien_reg <= ien_next;
    end
  end

  // Sequencing flops for sources and event crossing
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      instr_cnt_reg <= '0;
      ext_prev_reg <= 1'b0;
      armed_reg <= 1'b0;
      tog_reg <= 1'b0;
      tog_seen_reg <= 1'b0;
    end else begin
      instr_cnt_reg <= instr_cnt_next;
      ext_prev_reg <= ext_sel;
      armed_reg <= armed_next;
      tog_reg <= tog_reg ^ pre_tick;
      tog_seen_reg <= tog_sync;
    end
  end

  // Read port and port data: pins read zero while the crystal owns them
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= 8'h00;
      pin_read_reg <= 2'b00;
    end else begin
      rdata_reg <= i_rd ? rd_mux : 8'h00;
      pin_read_reg <= osc_en ? 2'b00 : {i_osc_input_pin, i_ext_count_pin};
    end
  end

  // Outputs
  assign o_rdata = rdata_reg;
  assign o_port_c_read = pin_read_reg;
  // Direction bits ignored while the crystal runs; 1 in direction means input
  assign o_pin_oe = osc_en ? 2'b00 : ~i_port_c_direction;
  assign o_osc_enable = osc_en;
  assign o_overflow_flag = flag_reg;
  assign o_overflow_irq = flag_reg & ien_reg;
  // Only an unsynchronised counter can still advance to wake the core
  assign o_wake = flag_reg & ien_reg & i_sleep;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_wrap;
    inc_tick && at_max && !wr_count && !cmp_any |=> (count_reg == 16'h0000) && flag_reg;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not zero and flag");

  property p_flag_sticky;
    flag_reg && !wr_flag |=> flag_reg;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_irq;
    o_overflow_irq |-> flag_reg && ien_reg;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enable");

  property p_halt;
    !run && !wr_count && !cmp_any |=> $stable(count_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved while stopped");

  property p_write_wins;
    wr_lo && cmp_any |=> count_reg[7:0] == $past(i_wdata);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("reset beat write");

  property p_cmp;
    cmp_any && !wr_count |=> count_reg == 16'h0000;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare reset ignored");

  // Unarmed unsynchronised counter must hold its value
  property p_arm;
    counter_on && !armed_reg && !use_sync && !wr_count && !cmp_any |=> $stable(count_reg);
  endproperty
  a_arm: assert property (p_arm) else $error("counted before falling edge");

  property p_sleep_sync;
    i_sleep && use_sync |-> !inc_tick;
  endproperty
  a_sleep_sync: assert property (p_sleep_sync) else $error("synced count in sleep");

  // Enables drop at once; port data follows one edge later
  property p_pins;
    osc_en |-> (o_pin_oe == 2'b00) ##1 (o_port_c_read == 2'b00);
  endproperty
  a_pins: assert property (p_pins) else $error("pins not released");

  property p_timer_rate;
    !cs && run && ps_code == 2'b00 && !i_sleep ##1 instr_tick |-> ##1 !instr_tick [*3];
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("instruction tick rate");

  // Arming only on a falling edge of the selected input
  property p_arm_fall;
    counter_on && !armed_reg && !ext_fall |=> !armed_reg;
  endproperty
  a_arm_fall: assert property (p_arm_fall) else $error("armed without fall");

  // High byte write lands even beside a compare reset
  property p_write_hi;
    wr_hi |=> count_hi == $past(i_wdata);
  endproperty
  a_write_hi: assert property (p_write_hi) else $error("high byte write lost");

  // A low byte write leaves the high byte alone
  property p_write_keep;
    wr_lo |=> count_hi == $past(count_hi);
  endproperty
  a_write_keep: assert property (p_write_keep) else $error("high byte disturbed");

  // Count low byte read returns the sampled byte
  property p_rd_count;
    i_rd && (i_addr == `TC_ADDR_COUNT_LO) |=> o_rdata == $past(count_lo);
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("count read wrong");

  // Control read shows zeros in the unused top bits
  property p_ctl_read;
    i_rd && (i_addr == `TC_ADDR_CONTROL) |=> o_rdata == {2'b00, $past(control_reg)};
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");

  // Read data is zero outside the answer cycle
  property p_rdata_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");

  // Control write keeps only the implemented bits
  property p_ctl_write;
    wr_ctrl |=> {2'b00, control_reg} == ($past(i_wdata) & 8'h3F);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

  // Every undisturbed increment below the top adds exactly one
  property p_step;
    inc_tick && !at_max && !wr_count && !cmp_any |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count step wrong");

  // Unsynchronised counter keeps advancing in sleep
  property p_sleep_async;
    i_sleep && cs && sync_n && run && pre_tick && !at_max && !wr_count && !cmp_any
      |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_sleep_async: assert property (p_sleep_async) else $error("async count stalled");

  // Compare reset never touches the flag
  property p_cmp_noflag;
    cmp_any && !wr_flag |=> $stable(flag_reg);
  endproperty
  a_cmp_noflag: assert property (p_cmp_noflag) else $error("compare set flag");

  // Software clear works when no wrap competes
  property p_flag_clear;
    wr_flag && !i_wdata[`TC_FLAG_BIT] && !overflow |=> !flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");

  // Free pins report their levels one edge later
  property p_pin_read;
    !osc_en |=> o_port_c_read == {$past(i_osc_input_pin), $past(i_ext_count_pin)};
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("port data wrong");

  // Main scenarios to be seen at least once
  c_wrap: cover property (overflow);
  c_write_vs_cmp: cover property (wr_count && cmp_any);
  c_ext_count: cover property (cs && sync_n && inc_tick);
  c_sync_count: cover property (use_sync && inc_tick);
  c_sleep_async: cover property (i_sleep && cs && sync_n && inc_tick);
endmodule

// >>> testbench/ext_clk_src.sv
// Model of an external clock source driving one count pin
module ext_clk_src (
  input wire logic i_clk,
  output logic o_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Stopped clock rests low between bursts
  initial o_level = 1'b0;
  // Park the pin at a fixed level
  task automatic hold(input logic lv);
    o_level <= lv;
  endtask
  // Burst of n pulses, two clocks high then two low
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      o_level <= 1'b1;
      repeat (2) @(posedge i_clk);
      o_level <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask
endmodule

// >>> testbench/timer_counter16_bench.sv
// Self-checking bench for the 16-bit timer/counter
`include "timer_counter16_params.svh"
module timer_counter16_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] a_ctl = `TC_ADDR_CONTROL;
  localparam logic [7:0] a_flg = `TC_ADDR_FLAG;
  localparam logic [7:0] a_ien = `TC_ADDR_ENABLE;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [1:0] i_cmp_reset = 2'h0;
  logic i_sleep = 1'b0;
  logic [1:0] i_port_c_direction = 2'h3;
  logic [7:0] o_rdata;
  logic [1:0] o_pin_oe;
  logic [1:0] o_port_c_read;
  logic o_osc_enable;
  logic o_overflow_flag;
  logic o_overflow_irq;
  logic o_wake;
  logic osc_pin;
  logic cnt_pin;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [15:0] v;
  logic [15:0] w;
  logic [7:0] b;
  // 20 MHz clock
  always #25 i_clk = ~i_clk;
  // Crystal side and count pin side sources
  ext_clk_src src_osc (.i_clk(i_clk), .o_level(osc_pin));
  ext_clk_src src_cnt (.i_clk(i_clk), .o_level(cnt_pin));
  timer_counter16 i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cmp_reset(i_cmp_reset), .i_sleep(i_sleep), .i_osc_input_pin(osc_pin),
    .i_ext_count_pin(cnt_pin), .i_port_c_direction(i_port_c_direction),
    .o_pin_oe(o_pin_oe), .o_port_c_read(o_port_c_read), .o_osc_enable(o_osc_enable),
    .o_overflow_flag(o_overflow_flag), .o_overflow_irq(o_overflow_irq), .o_wake(o_wake));
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Range compare; an exact check passes lo equal to hi
  task automatic chk(input string nm, input logic [15:0] lo, hi, s);
    n_tests++;
    if ($isunknown(s) || s < lo || s > hi) begin
      error_cnt++;
      $display("MISMATCH %s exp %h..%h seen %h", nm, lo, hi, s);
    end
  endtask
  // One-cycle write strobe; an idle edge follows so the strobe is never set twice at once
  task automatic wr(input logic [7:0] a, d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 q = o_rdata;
    @(posedge i_clk);
  endtask
  // Count is read low then high; only safe while halted
  task automatic rdc(output logic [15:0] c);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(`TC_ADDR_COUNT_LO, lo);
    rd(`TC_ADDR_COUNT_HI, hi);
    c = {hi, lo};
  endtask
  task automatic wcount(input logic [15:0] c);
    wr(`TC_ADDR_COUNT_HI, c[15:8]);
    wr(`TC_ADDR_COUNT_LO, c[7:0]);
  endtask
  // Counter mode burst; the pin idles low so the first rise has no fall before it
  task automatic cnt(input logic [7:0] ctl, input logic osc, input logic [15:0] e,
    input string nm);
    logic [15:0] c;
    wcount(16'h0000);
    wr(a_ctl, ctl);
    if (osc) src_osc.pulses(5);
    else src_cnt.pulses(5);
    repeat (8) @(posedge i_clk);
    wr(a_ctl, 8'h00);
    rdc(c);
    chk(nm, e, e, c);
  endtask
  // Hang guard, well above the tests' length
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    rd(a_ctl, b);
    chk("ctl_rst", 16'h0, 16'h0, {8'h00, b});
    chk("osc_rst", 16'h0, 16'h0, {15'h0, o_osc_enable});
    wr(a_ctl, 8'hC0);
    rd(a_ctl, b);
    chk("ctl_top", 16'h0, 16'h0, {8'h00, b});
    rd(8'h20, b);
    chk("unmapped", 16'h0, 16'h0, {8'h00, b});
    wcount(16'hA55A);
    rdc(v);
    chk("count_rw", 16'hA55A, 16'hA55A, v);
    $display("test registers done");
    // Sixteen clocks times the divide ratio give four counts at every code
    for (int p = 0; p < 4; p++) begin
      wcount(16'h0000);
      wr(a_ctl, {2'b00, 2'(p), 4'b0101});
      repeat (16 * (1 << p) - 1) @(posedge i_clk);
      wr(a_ctl, 8'h00);
      rdc(v);
      chk("timer", 16'd3, 16'd5, v);
      repeat (20) @(posedge i_clk);
      rdc(w);
      chk("halt", v, v, w);
    end
    $display("test timer done");
    wr(a_ien, 8'h00);
    wr(a_flg, 8'h00);
    wcount(16'hFFFE);
    wr(a_ctl, 8'h01);
    repeat (12) @(posedge i_clk);
    wr(a_ctl, 8'h00);
    rdc(v);
    chk("wrap", 16'h0000, 16'h0002, v);
    @(negedge i_clk);
    chk("flag", 16'h1, 16'h1, {15'h0, o_overflow_flag});
    chk("irq_off", 16'h0, 16'h0, {15'h0, o_overflow_irq});
    @(posedge i_clk);
    wr(a_ien, 8'h01);
    i_sleep <= 1'b1;
    @(negedge i_clk);
    chk("irq_on", 16'h1, 16'h1, {15'h0, o_overflow_irq});
    chk("wake", 16'h1, 16'h1, {15'h0, o_wake});
    @(posedge i_clk);
    i_sleep <= 1'b0;
    rd(a_flg, b);
    chk("flag_held", 16'h1, 16'h1, {8'h00, b});
    chk("wake_off", 16'h0, 16'h0, {15'h0, o_wake});
    wr(a_flg, 8'h00);
    @(negedge i_clk);
    chk("flag_clr", 16'h0, 16'h0, {15'h0, o_overflow_flag});
    @(posedge i_clk);
    $display("test overflow done");
    wcount(16'h1234);
    i_cmp_reset <= 2'b10;
    @(posedge i_clk);
    i_cmp_reset <= 2'b00;
    rdc(v);
    chk("cmp_rst", 16'h0, 16'h0, v);
    chk("cmp_noflag", 16'h0, 16'h0, {15'h0, o_overflow_flag});
    wr(`TC_ADDR_COUNT_HI, 8'h34);
    // Compare pulse lands on the very edge that takes the write
    fork
      wr(`TC_ADDR_COUNT_LO, 8'h55);
      begin
        i_cmp_reset <= 2'b01;
        @(posedge i_clk);
        i_cmp_reset <= 2'b00;
      end
    join
    rdc(v);
    chk("write_wins", 16'h3455, 16'h3455, v);
    $display("test compare reset done");
    cnt(8'h07, 1'b0, 16'd4, "async");
    i_sleep <= 1'b1;
    cnt(8'h07, 1'b0, 16'd4, "async_sleep");
    cnt(8'h03, 1'b0, 16'd0, "sync_sleep");
    i_sleep <= 1'b0;
    cnt(8'h03, 1'b0, 16'd4, "sync");
    cnt(8'h13, 1'b0, 16'd2, "sync_div2");
    cnt(8'h0F, 1'b1, 16'd4, "osc_src");
    cnt(8'h0F, 1'b0, 16'd0, "osc_not_pin");
    cnt(8'h07, 1'b1, 16'd0, "pin_not_osc");
    $display("test counter done");
    i_port_c_direction <= 2'b01;
    wr(a_ctl, 8'h08);
    // Pins high so the forced zero read is visible
    src_osc.hold(1'b1);
    src_cnt.hold(1'b1);
    @(posedge i_clk);
    @(negedge i_clk);
    chk("oe_osc", 16'h0, 16'h0, {14'h0, o_pin_oe});
    chk("pins_osc", 16'h0, 16'h0, {14'h0, o_port_c_read});
    chk("osc_on", 16'h1, 16'h1, {15'h0, o_osc_enable});
    @(posedge i_clk);
    wr(a_ctl, 8'h00);
    @(negedge i_clk);
    chk("oe_port", 16'h2, 16'h2, {14'h0, o_pin_oe});
    chk("osc_off", 16'h0, 16'h0, {15'h0, o_osc_enable});
    chk("pins_port", 16'h3, 16'h3, {14'h0, o_port_c_read});
    $display("test pins done");
    complete_run();
  end
endmodule
